// ===== hdl/vref_lsd_pkg.sv
// Package of register offsets, field positions and reset values for the reference and low-supply block.
package vref_lsd_pkg;
   localparam logic [7:0] reference_control_addr = 8'h9b;
   localparam logic [7:0] low_supply_detect_control_addr = 8'h9c;
   localparam logic [7:0] flag_control_addr = 8'h9d;
   localparam int high_ref_enable_bit = 7;
   localparam int low_ref_enable_bit = 6;
   localparam int high_ref_output_enable_bit = 5;
   localparam int low_ref_output_enable_bit = 4;
   localparam int bandgap_stable_bit = 5;
   localparam int detector_enable_bit = 4;
   localparam int low_supply_flag_bit = 0;
   localparam int low_supply_irq_enable_bit = 1;
   localparam logic [3:0] trip_level_reset = 4'h5;
   localparam logic [3:0] trip_external = 4'hf;
   localparam logic [3:0] trip_lowest_valid = 4'h4;
   localparam logic [3:0] reference_control_reset = 4'h0;
endpackage : vref_lsd_pkg

// ===== hdl/analog_status_if.sv
// Interface carrying synchronised analog indications between the block's modules.
`timescale 1ns/10ps
interface analog_status_if;
   logic bandgap_stable;
   logic below_trip;
   modport source (output bandgap_stable, output below_trip);
   modport sink (input bandgap_stable, input below_trip);
endinterface : analog_status_if

// ===== hdl/level_sync.sv
// Three-stage synchroniser that accepts a change once the second and third stages agree.
`timescale 1ns/10ps
module level_sync (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } state_type;
   state_type state;
   state_type next_state;

   // Only the second stage reads the first; the agreement check looks at stages two and three.
   always_comb begin
      next_state = state;
      next_state.s1 = async_in;
      next_state.s2 = state.s1;
      next_state.s3 = state.s2;
      if (state.s2 == state.s3) begin
         next_state.level = state.s3;
      end
   end

   // All stages clear on reset so outputs are defined at once.
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.level;
endmodule : level_sync

// ===== hdl/analog_front_sync.sv
// Synchronises the bandgap-stable and below-trip indications onto the core clock.
`timescale 1ns/10ps
module analog_front_sync (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic bandgap_stable_in,
   input wire logic below_trip_in,
   analog_status_if.source status
);
   // Each analog indication gets its own synchroniser.
   level_sync stable_sync (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .async_in(bandgap_stable_in),
      .sync_out(status.bandgap_stable)
   );
   level_sync trip_sync (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .async_in(below_trip_in),
      .sync_out(status.below_trip)
   );
endmodule : analog_front_sync

// ===== hdl/vref_lsd_ctrl.sv
// Control logic for the bandgap reference, the two reference amplifiers and the low-supply detector.
//
// Operation
// [R1] Bandgap powered when brown-out, detector or either reference is enabled; else off.
// [R2] Detector control bit 5 reads one once bandgap is stable.
// [R3] Low-supply flag cannot set until bandgap stability is seen.
// [R4] Detector control bit 4 enables the detector and requests the bandgap.
// [R5] Enabled, stable, supply at or below trip sets flag; interrupt needs enable.
// [R6] Bits 3-0 select trip level; 1111 external, 1110-0100 internal, rest reserved.
// [R7] Trip code 1111 routes comparator threshold from external pin.
// [R8] Flag stays set, ignoring clears, while supply is at or below trip.
// [R9] Software should clear interrupt enable after first low-supply interrupt.
// [R10] Pending enabled low-supply interrupt wakes the device from sleep.
// [R11] Reference bit 7 enables high reference amplifier and requests bandgap.
// [R12] Reference bit 6 enables low reference amplifier and requests bandgap.
// [R13] Bit 5 with high reference enabled drives it onto its pin.
// [R14] Bit 4 with low reference enabled drives it onto its pin.
// [R15] Output enable without reference enable has no effect; pin stays general I/O.
// [R16] Software should poll stability bit before using references.
// [R17] Reference bits 3-0 and detector bits 7-6 read zero.
// [R18] Software should not program reserved trip codes.
// [R19] Reset loads trip 0101, clears enables and reference control.
// [R20] Analog stable and below-trip indications are synchronised before use.
`timescale 1ns/10ps
module vref_lsd_ctrl
   import vref_lsd_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [7:0] rdata_out,
   input wire logic brownout_reset_enable_in,
   input wire logic bandgap_stable_in,
   input wire logic below_trip_in,
   output logic bandgap_power_out,
   output logic high_ref_amp_enable_out,
   output logic low_ref_amp_enable_out,
   output logic high_ref_pin_drive_out,
   output logic low_ref_pin_drive_out,
   output logic detector_power_out,
   output logic [3:0] trip_level_select_out,
   output logic external_trip_input_select_out,
   output logic low_supply_flag_out,
   output logic low_supply_irq_out,
   output logic wake_out
);
   typedef struct packed {
      logic [3:0] reference_control;
      logic detector_enable;
      logic [3:0] trip_level_select;
      logic low_supply_flag;
      logic low_supply_irq_enable;
      logic [7:0] rdata;
      logic bandgap_power;
      logic high_ref_amp;
      logic low_ref_amp;
      logic high_ref_pin;
      logic low_ref_pin;
      logic detector_power;
      logic external_select;
      logic irq;
   } state_type;

   state_type state;
   state_type next_state;
   analog_status_if status ();

   // Stability and below-trip come from the analog side on no clock of ours.
   analog_front_sync front ( // R20
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .bandgap_stable_in(bandgap_stable_in),
      .below_trip_in(below_trip_in),
      .status(status)
   );

   // Assemble a readable register image; unimplemented bits are zero.
   function automatic logic [7:0] read_image(input state_type s, input logic stable, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == reference_control_addr) begin
         v = {s.reference_control, 4'h0}; // R17
      end else if (a == low_supply_detect_control_addr) begin
         v = {2'b00, stable, s.detector_enable, s.trip_level_select}; // R2 R17
      end else if (a == flag_control_addr) begin
         v = {6'h00, s.low_supply_irq_enable, s.low_supply_flag};
      end
      return v;
   endfunction : read_image

   // Register writes, flag handling and derived analog controls in one pass.
   always_comb begin
      logic detector_live;
      logic stable;
      detector_live = 1'b0;
      stable = status.bandgap_stable;
      next_state = state;
      next_state.rdata = 8'h00;
      if (read_in) begin
         next_state.rdata = read_image(state, stable, addr_in);
      end
      if (write_in) begin
         if (addr_in == reference_control_addr) begin
            next_state.reference_control = wdata_in[7:4]; // R11 R12
         end else if (addr_in == low_supply_detect_control_addr) begin
            next_state.detector_enable = wdata_in[detector_enable_bit]; // R4
            next_state.trip_level_select = wdata_in[3:0]; // R6
         end else if (addr_in == flag_control_addr) begin
            next_state.low_supply_irq_enable = wdata_in[low_supply_irq_enable_bit];
            // A software clear only sticks once the supply is back above the trip point.
            if (!wdata_in[low_supply_flag_bit] && !status.below_trip) begin // R8
               next_state.low_supply_flag = 1'b0;
            end
         end
      end
      // The flag set is gated on stability and wins over a clear in the same cycle.
      detector_live = state.detector_enable && stable; // R3
      if (detector_live && status.below_trip) begin // R5
         next_state.low_supply_flag = 1'b1;
      end
      next_state.bandgap_power = brownout_reset_enable_in || next_state.detector_enable ||
         next_state.reference_control[3] || next_state.reference_control[2]; // R1
      next_state.high_ref_amp = next_state.reference_control[3]; // R11
      next_state.low_ref_amp = next_state.reference_control[2]; // R12
      // An output enable without the matching reference enable leaves the pin to general I/O.
      next_state.high_ref_pin = next_state.reference_control[3] && next_state.reference_control[1]; // R13 R15
      next_state.low_ref_pin = next_state.reference_control[2] && next_state.reference_control[0]; // R14 R15
      next_state.detector_power = next_state.detector_enable; // R4
      next_state.external_select = next_state.trip_level_select == trip_external; // R7
      next_state.irq = next_state.low_supply_flag && next_state.low_supply_irq_enable; // R5 R10
   end

   // Reset leaves the detector off with the default trip code.
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= '0;
         state.trip_level_select <= trip_level_reset; // R19
         state.reference_control <= reference_control_reset; // R19
      end else begin
         state <= next_state;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign rdata_out = state.rdata;
   assign bandgap_power_out = state.bandgap_power;
   assign high_ref_amp_enable_out = state.high_ref_amp;
   assign low_ref_amp_enable_out = state.low_ref_amp;
   assign high_ref_pin_drive_out = state.high_ref_pin;
   assign low_ref_pin_drive_out = state.low_ref_pin;
   assign detector_power_out = state.detector_power;
   assign trip_level_select_out = state.trip_level_select;
   assign external_trip_input_select_out = state.external_select;
   assign low_supply_flag_out = state.low_supply_flag;
   assign low_supply_irq_out = state.irq;
   assign wake_out = state.irq; // R10
endmodule : vref_lsd_ctrl

// ===== sim/analog_model.sv
// Behavioural model of the bandgap, its stability indication and the trip comparator.
`timescale 1ns/10ps
module analog_model #(parameter int start_cycles = 20) (
   input wire logic ref_clk_in,
   input wire logic power_in,
   input wire logic [3:0] trip_in,
   input wire logic ext_sel_in,
   input wire logic [15:0] supply_mv_in,
   output logic stable_out,
   output logic below_out
);
   int cnt = 0;
   int mv [4:14] = '{2500, 2700, 2800, 3000, 3300, 3500, 3600, 3800, 4000, 4200, 4500};
   // Stability is lost at once on power down, so every restart pays the full start-up time.
   always @(posedge ref_clk_in) begin
      cnt <= power_in ? cnt + 1 : 0;
   end
   assign stable_out = power_in && cnt >= start_cycles;
   // The external pin sits at 3100 mV; reserved codes always trip, as a real comparator may.
   assign below_out = ext_sel_in ? supply_mv_in <= 3100 : (trip_in < 4 || supply_mv_in <= mv[trip_in]);
endmodule : analog_model

// ===== sim/vref_lsd_ctrl_sva.sv
// Concurrent checks on the ports of the reference and low-supply control block.
`timescale 1ns/10ps
module vref_lsd_ctrl_sva (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic brownout_reset_enable_in,
   input wire logic bandgap_stable_in,
   input wire logic below_trip_in,
   input wire logic bandgap_power_out,
   input wire logic high_ref_amp_enable_out,
   input wire logic low_ref_amp_enable_out,
   input wire logic high_ref_pin_drive_out,
   input wire logic low_ref_pin_drive_out,
   input wire logic detector_power_out,
   input wire logic [3:0] trip_level_select_out,
   input wire logic external_trip_input_select_out,
   input wire logic low_supply_flag_out,
   input wire logic low_supply_irq_out,
   input wire logic wake_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   chk_bandgap_request: assert property (bandgap_power_out == ($past(brownout_reset_enable_in) | detector_power_out
      | high_ref_amp_enable_out | low_ref_amp_enable_out)) else $error("bandgap power mismatch");
   chk_high_pin_gate: assert property (high_ref_pin_drive_out |-> high_ref_amp_enable_out)
      else $error("high pin driven while off");
   chk_low_pin_gate: assert property (low_ref_pin_drive_out |-> low_ref_amp_enable_out)
      else $error("low pin driven while off");
   chk_external_route: assert property (external_trip_input_select_out == (trip_level_select_out == 4'hf))
      else $error("external select mismatch");
   chk_irq_source: assert property (low_supply_irq_out |-> low_supply_flag_out)
      else $error("irq without flag");
   chk_wake_source: assert property (wake_out == low_supply_irq_out) else $error("wake mismatch");
   chk_flag_gating: assert property ($rose(low_supply_flag_out) |-> $past(bandgap_stable_in, 2)
      && $past(below_trip_in, 2) && $past(detector_power_out)) else $error("flag set without cause");
   chk_flag_sticky: assert property ($fell(low_supply_flag_out) |-> !$past(below_trip_in, 2))
      else $error("flag cleared while low");
endmodule : vref_lsd_ctrl_sva
bind vref_lsd_ctrl vref_lsd_ctrl_sva chk (.*);

// ===== sim/tb_top.sv
// Self-checking bench for the reference and low-supply control block.
`timescale 1ns/10ps
module tb_top;
   import vref_lsd_pkg::*;
   localparam logic [7:0] det_a = low_supply_detect_control_addr;
   localparam logic [7:0] ref_a = reference_control_addr;
   localparam logic [7:0] flg_a = flag_control_addr;
   logic ref_clk_in = 0, rst_b_in = 0, write_in = 0, read_in = 0, brown = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic bg, stable, below, hi_amp, lo_amp, hi_drv, lo_drv, det, ext, flag, irq, wake;
   logic [3:0] trip;
   logic [15:0] supply = 16'd5000;
   int fails = 0, samples_checked = 0, cycles = 0;
   vref_lsd_ctrl dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .write_in(write_in),
      .read_in(read_in), .rdata_out(rdata), .brownout_reset_enable_in(brown), .bandgap_stable_in(stable),
      .below_trip_in(below), .bandgap_power_out(bg), .high_ref_amp_enable_out(hi_amp), .low_ref_amp_enable_out(lo_amp),
      .high_ref_pin_drive_out(hi_drv), .low_ref_pin_drive_out(lo_drv), .detector_power_out(det),
      .trip_level_select_out(trip), .external_trip_input_select_out(ext), .low_supply_flag_out(flag),
      .low_supply_irq_out(irq), .wake_out(wake));
   analog_model model (.ref_clk_in(ref_clk_in), .power_in(bg), .trip_in(trip), .ext_sel_in(ext),
      .supply_mv_in(supply), .stable_out(stable), .below_out(below));
   // Free-running core clock and a cycle ceiling that cuts a hang short.
   initial begin
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         summarize();
      end
   end
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= d;
      write_in <= 1'b1;
      @(posedge ref_clk_in);
      write_in <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so it is taken just after that edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      addr <= a;
      read_in <= 1'b1;
      @(posedge ref_clk_in);
      read_in <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   // Main sequence: reset, reference control, brown-out, trip codes, then the detector.
   initial begin
      logic [7:0] d;
      repeat (6) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      rd(det_a, d);
      check("detect reset", 8'h05, d);
      rd(ref_a, d);
      check("ref reset", 8'h00, d);
      wr(ref_a, 8'hff);
      rd(ref_a, d);
      check("ref read", 8'hf0, d);
      check("ref all on", 8'h1f, {3'h0, bg, hi_amp, lo_amp, hi_drv, lo_drv});
      wr(ref_a, 8'h30);
      rd(ref_a, d);
      check("ref oe read", 8'h30, d);
      check("ref oe only", 8'h00, {3'h0, bg, hi_amp, lo_amp, hi_drv, lo_drv});
      wr(ref_a, 8'h50);
      rd(ref_a, d);
      check("ref low read", 8'h50, d);
      check("ref low on", 8'h15, {3'h0, bg, hi_amp, lo_amp, hi_drv, lo_drv});
      wr(ref_a, 8'h00);
      brown <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      check("brownout power", 8'h01, {7'h0, bg});
      brown <= 1'b0;
      // Reserved trip codes are never programmed, as software is told to avoid them.
      for (int c = 4; c < 16; c++) begin
         wr(det_a, 8'(c));
         rd(det_a, d);
         check("trip read", 8'(c), d);
         check("trip out", {3'h0, c == 15, 4'(c)}, {3'h0, ext, trip});
      end
      supply <= 16'd2000;
      wr(det_a, 8'h1d);
      rd(det_a, d);
      check("not yet stable", 8'h1d, d);
      check("flag gated", 8'h03, {5'h0, flag, det, bg});
      for (int i = 0; i < 40 && d[5] !== 1'b1; i++)
         rd(det_a, d);
      check("stable", 8'h3d, d);
      repeat (8) @(posedge ref_clk_in);
      #1 check("flag no irq", 8'h01, {6'h0, irq, flag});
      wr(flg_a, 8'h02);
      rd(flg_a, d);
      check("irq wake", 8'h07, {5'h0, wake, irq, flag});
      wr(flg_a, 8'h02);
      rd(flg_a, d);
      check("flag held", 8'h03, d);
      wr(flg_a, 8'h00);
      rd(flg_a, d);
      check("irq off flag held", 8'h01, {d[7:2], irq, flag});
      supply <= 16'd5000;
      repeat (8) @(posedge ref_clk_in);
      wr(flg_a, 8'h00);
      rd(flg_a, d);
      check("flag cleared", 8'h00, d);
      rd(8'h9e, d);
      check("unmapped", 8'h00, d);
      summarize();
   end
endmodule : tb_top
